// File: rtl/ddu_pkg.sv
// Shared constants for the dual converter serial update link
package ddu_pkg;
	localparam int          DDU_FRAME_BITS  = 24;
	localparam int          DDU_CODE_BITS   = 16;
	localparam int          DDU_CMD_MSB     = 23;
	localparam int          DDU_CMD_LSB     = 20;
	localparam int          DDU_CHAN_MSB    = 19;
	localparam int          DDU_CHAN_LSB    = 16;
	localparam logic [3:0]  DDU_CMD_WRITE   = 4'h1;
	localparam logic [3:0]  DDU_CMD_WR_UPD  = 4'h3;
	localparam logic [3:0]  DDU_CMD_POWER   = 4'h4;
	localparam logic [3:0]  DDU_CHAN_A      = 4'h1;
	localparam logic [3:0]  DDU_CHAN_B      = 4'h8;
	localparam logic [15:0] DDU_ZERO_SCALE  = 16'h0000;
	localparam logic [15:0] DDU_FULL_SCALE  = 16'hFFFF;
	localparam logic [15:0] DDU_MID_SCALE   = 16'h8000;
	localparam int          DDU_CLK_MHZ     = 100;
	localparam int          DDU_PWRUP_NS    = 4500;
	localparam int          DDU_PWRUP_CYC   = (DDU_PWRUP_NS * DDU_CLK_MHZ + 999) / 1000;
	localparam int          DDU_SCLK_DIV    = 8;
	localparam logic [5:0]  DDU_OFS_CTRL    = 6'h00;
	localparam logic [5:0]  DDU_OFS_WORD    = 6'h04;
	localparam logic [5:0]  DDU_OFS_STATUS  = 6'h08;
	localparam logic [5:0]  DDU_OFS_RDBK    = 6'h0C;
	localparam logic [1:0]  DDU_RESP_OKAY   = 2'b00;
	localparam logic [1:0]  DDU_RESP_SLVERR = 2'b10;
endpackage

// File: rtl/ddu_link_if.sv
// Serial link between the host controller and the converter
interface ddu_link_if;
	logic frame_n;
	logic sclk;
	logic serial_data_in;
	logic serial_data_out;
	logic load_strobe_n;
	logic reset_n;
	logic reset_level_select;
	logic gain_select;
	modport host
	(
		output frame_n, sclk, serial_data_in, load_strobe_n, reset_n,
		output reset_level_select, gain_select,
		input  serial_data_out
	);
	modport device
	(
		input  frame_n, sclk, serial_data_in, load_strobe_n, reset_n,
		input  reset_level_select, gain_select,
		output serial_data_out
	);
endinterface

// File: rtl/ddu_fifo.sv
// Word FIFO with valid and ready on both sides
module ddu_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
)
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	// Pointer wrap relies on a power-of-two depth
	if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH)
	begin
		$error("ddu_fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
	logic             push, pop;
	always_comb
	begin
		push = in_valid && in_ready;
		pop  = out_valid && out_ready;
		wp_d = wp_q + (AW+1)'(push);
		rp_d = rp_q + (AW+1)'(pop);
	end
	assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
	assign out_valid = wp_q != rp_q;
	assign out_data  = mem[rp_q[AW-1:0]];
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wp_q <= '0;
			rp_q <= '0;
		end
		else
		begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
		if (push)
			mem[wp_q[AW-1:0]] <= in_data;
	end
endmodule

// File: rtl/ddu_device.sv
// Converter end: shift register, input and output registers, load and reset
// What this block does
// - Sample data bit on serial clock fall
// - Frame low, then 24 falling edges accepted
// - One 24-bit word per frame, order kept
// - Serial out changes on rising edges
// - Serial out chains or returns readback
// - Load low copies pending input to outputs
// - Host pulses load or holds it low
// - Reset acts on its falling edge
// - Load ignored while reset held low
// - Reset loads zero or midscale everywhere
// - Power-on value follows reset select
// - Gain pin chooses one or two spans
// - Zero code zero, all ones full
// - Power-up needs 4.5 us after edge 24
module ddu_device
	import ddu_pkg::*;
(
	input  wire logic               aclk,
	input  wire logic               aresetn,
	ddu_link_if.device              link,
	output logic [DDU_CODE_BITS-1:0] out_code_a_q,
	output logic [DDU_CODE_BITS-1:0] out_code_b_q,
	output logic                    span_double_q,
	output logic [1:0]              ready_q
);
	logic [1:0]                fr_s;
	logic [1:0]                ck_s;
	logic [1:0]                di_s;
	logic [1:0]                ld_s;
	logic [1:0]                rs_s;
	logic [1:0]                rl_s;
	logic [1:0]                gn_s;
	logic                      ck_prev_q;
	logic                      rs_prev_q;
	logic [DDU_FRAME_BITS-1:0] sh_q;
	logic [DDU_FRAME_BITS-1:0] sh_d;
	logic [DDU_FRAME_BITS-1:0] chain_q;
	logic [DDU_FRAME_BITS-1:0] chain_d;
	logic [4:0]                cnt_q;
	logic [4:0]                cnt_d;
	logic [DDU_CODE_BITS-1:0]  in_a_q;
	logic [DDU_CODE_BITS-1:0]  in_a_d;
	logic [DDU_CODE_BITS-1:0]  in_b_q;
	logic [DDU_CODE_BITS-1:0]  in_b_d;
	logic [DDU_CODE_BITS-1:0]  oa_d;
	logic [DDU_CODE_BITS-1:0]  ob_d;
	logic [1:0]                new_q;
	logic [1:0]                new_d;
	logic [1:0]                pd_q;
	logic [1:0]                pd_d;
	logic [1:0]                rdy_d;
	logic                      sdo_q;
	logic                      sdo_d;
	logic [1:0]                init_q;
	logic [15:0]               pu_q [2];
	logic [15:0]               pu_d [2];
	logic                      fall;
	logic                      rise;
	logic                      rst_edge;
	logic                      word_done;
	logic [DDU_FRAME_BITS-1:0] word;
	logic [DDU_CODE_BITS-1:0]  rst_val;
	always_ff @(posedge aclk)
	begin
		fr_s <= {fr_s[0], link.frame_n};
		ck_s <= {ck_s[0], link.sclk};
		di_s <= {di_s[0], link.serial_data_in};
		ld_s <= {ld_s[0], link.load_strobe_n};
		rs_s <= {rs_s[0], link.reset_n};
		rl_s <= {rl_s[0], link.reset_level_select};
		gn_s <= {gn_s[0], link.gain_select};
	end
	always_comb
	begin
		fall      = ck_prev_q && !ck_s[1];
		rise      = !ck_prev_q && ck_s[1];
		rst_edge  = rs_prev_q && !rs_s[1];
		rst_val   = rl_s[1] ? DDU_MID_SCALE : DDU_ZERO_SCALE;
		word      = {sh_q[DDU_FRAME_BITS-2:0], di_s[1]};
		word_done = 1'b0;
		sh_d    = sh_q;
		cnt_d   = cnt_q;
		chain_d = chain_q;
		sdo_d   = sdo_q;
		in_a_d  = in_a_q;
		in_b_d  = in_b_q;
		oa_d    = out_code_a_q;
		ob_d    = out_code_b_q;
		new_d   = new_q;
		pd_d    = pd_q;
		if (fr_s[1])
			cnt_d = '0;
		else if (fall && cnt_q < 5'(DDU_FRAME_BITS))
		begin
			sh_d  = word;
			cnt_d = cnt_q + 5'd1;
			word_done = cnt_q == 5'(DDU_FRAME_BITS - 1);
		end
		if (rise && !fr_s[1])
		begin
			sdo_d   = chain_q[DDU_FRAME_BITS-1];
			chain_d = {chain_q[DDU_FRAME_BITS-2:0], 1'b0};
		end
		// Load clears pending flags first, so a word finishing in a load cycle stays pending
		if (!ld_s[1] && rs_s[1])
		begin
			if (new_q[0])
				oa_d = in_a_q;
			if (new_q[1])
				ob_d = in_b_q;
			new_d = 2'b00;
		end
		if (word_done)
		begin
			// Top bit set asks for channel A's code on the next frame
			chain_d = word[DDU_FRAME_BITS-1] ? {8'h00, out_code_a_q} : word;
			if (word[DDU_CMD_MSB:DDU_CMD_LSB] == DDU_CMD_WRITE ||
				word[DDU_CMD_MSB:DDU_CMD_LSB] == DDU_CMD_WR_UPD)
			begin
				if ((word[DDU_CHAN_MSB:DDU_CHAN_LSB] & DDU_CHAN_A) != 4'h0)
				begin
					in_a_d   = word[DDU_CODE_BITS-1:0];
					new_d[0] = 1'b1;
				end
				if ((word[DDU_CHAN_MSB:DDU_CHAN_LSB] & DDU_CHAN_B) != 4'h0)
				begin
					in_b_d   = word[DDU_CODE_BITS-1:0];
					new_d[1] = 1'b1;
				end
			end
			if (word[DDU_CMD_MSB:DDU_CMD_LSB] == DDU_CMD_POWER)
				pd_d = word[1:0];
		end
		if (rst_edge)
		begin
			in_a_d = rst_val;
			in_b_d = rst_val;
			oa_d   = rst_val;
			ob_d   = rst_val;
			new_d  = 2'b00;
		end
		for (int i = 0; i < 2; i++)
		begin
			rdy_d[i] = !pd_q[i] && pu_q[i] == 16'h0;
			pu_d[i]  = pu_q[i] != 16'h0 ? pu_q[i] - 16'h1 : 16'h0;
			if (word_done && pd_q[i] && !pd_d[i])
				pu_d[i] = 16'(DDU_PWRUP_CYC);
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ck_prev_q <= 1'b0;
			rs_prev_q <= 1'b1;
			sh_q <= '0;
			cnt_q <= '0;
			chain_q <= '0;
			sdo_q <= 1'b0;
			in_a_q <= DDU_ZERO_SCALE;
			in_b_q <= DDU_ZERO_SCALE;
			out_code_a_q <= DDU_ZERO_SCALE;
			out_code_b_q <= DDU_ZERO_SCALE;
			new_q <= 2'b00;
			pd_q <= 2'b00;
			pu_q[0] <= 16'h0;
			pu_q[1] <= 16'h0;
			ready_q <= 2'b00;
			span_double_q <= 1'b0;
			init_q <= 2'b11;
		end
		else if (init_q != 2'b00)
		begin
			// Two cycles, so the strap value has crossed both synchroniser stages
			init_q <= {init_q[0], 1'b0};
			ck_prev_q <= ck_s[1];
			rs_prev_q <= rs_s[1];
			in_a_q <= rst_val;
			in_b_q <= rst_val;
			out_code_a_q <= rst_val;
			out_code_b_q <= rst_val;
		end
		else
		begin
			ck_prev_q <= ck_s[1];
			rs_prev_q <= rs_s[1];
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			chain_q <= chain_d;
			sdo_q <= sdo_d;
			in_a_q <= in_a_d;
			in_b_q <= in_b_d;
			out_code_a_q <= oa_d;
			out_code_b_q <= ob_d;
			new_q <= new_d;
			pd_q <= pd_d;
			pu_q[0] <= pu_d[0];
			pu_q[1] <= pu_d[1];
			ready_q <= rdy_d;
			span_double_q <= gn_s[1];
		end
	end
	assign link.serial_data_out = sdo_q;
endmodule

// File: rtl/ddu_host.sv
// Host end: AXI4-Lite registers, word FIFO and serial frame generator
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
module ddu_host
	import ddu_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	ddu_link_if.host         link
);
	typedef enum logic [1:0] {DDU_IDLE, DDU_LOW, DDU_HIGH, DDU_GAP} ddu_state_t;
	ddu_state_t st_q, st_d;
	logic [3:0]  ctrl_q, ctrl_d;
	logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
	logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;
	logic [5:0]  awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [1:0]  br_q, br_d, rr_q, rr_d;
	logic [23:0] tx_q, tx_d, rx_q, rx_d, rb_q, rb_d;
	logic [4:0]  bit_q, bit_d;
	logic [3:0]  div_q, div_d;
	logic        sclk_q, sclk_d, fr_q, fr_d, sdi_q, sdi_d;
	logic [1:0]  so_s;
	logic        push_v, push_r, pop_r, fifo_v, tick;
	logic [23:0] fifo_d;
	ddu_fifo #(.WIDTH(DDU_FRAME_BITS), .DEPTH(8)) u_fifo
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_data   (wd_q[23:0]),
		.in_valid  (push_v),
		.in_ready  (push_r),
		.out_data  (fifo_d),
		.out_valid (fifo_v),
		.out_ready (pop_r)
	);
	always_ff @(posedge aclk)
		so_s <= {so_s[0], link.serial_data_out};
	always_comb
	begin
		aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q; bv_d = bv_q; br_d = br_q;
		rv_d = rv_q; rd_d = rd_q; rr_d = rr_q; ctrl_d = ctrl_q;
		push_v = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_d = 1'b1;
			wd_d = s_axi_wdata;
		end
		if (s_axi_bvalid && s_axi_bready)
			bv_d = 1'b0;
		// Word writes wait for FIFO room, so back-pressure reaches software
		if (aw_q && w_q && !bv_q)
		begin
			br_d = DDU_RESP_OKAY;
			if (awa_q == DDU_OFS_CTRL)
				ctrl_d = wd_q[3:0];
			else if (awa_q == DDU_OFS_WORD)
				push_v = 1'b1;
			else if (awa_q != DDU_OFS_STATUS && awa_q != DDU_OFS_RDBK)
				br_d = DDU_RESP_SLVERR;
			if (awa_q != DDU_OFS_WORD || push_r)
			begin
				aw_d = 1'b0;
				w_d = 1'b0;
				bv_d = 1'b1;
			end
		end
		if (s_axi_rvalid && s_axi_rready)
			rv_d = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rv_d = 1'b1;
			rr_d = DDU_RESP_OKAY;
			case (s_axi_araddr)
				DDU_OFS_CTRL:   rd_d = {28'h0, ctrl_q};
				DDU_OFS_STATUS: rd_d = {29'h0, !push_r, fifo_v, st_q != DDU_IDLE};
				DDU_OFS_RDBK:   rd_d = {8'h0, rb_q};
				default:
				begin
					rd_d = 32'h0;
					rr_d = DDU_RESP_SLVERR;
				end
			endcase
		end
		awrdy_d = !aw_d && !bv_d;
		wrdy_d  = !w_d && !bv_d;
		arrdy_d = !rv_d;
	end
	always_comb
	begin
		st_d = st_q; tx_d = tx_q; rx_d = rx_q; rb_d = rb_q; bit_d = bit_q;
		sclk_d = sclk_q; fr_d = fr_q; sdi_d = sdi_q;
		pop_r = 1'b0;
		tick = div_q == 4'(DDU_SCLK_DIV - 1);
		div_d = tick ? 4'h0 : div_q + 4'h1;
		if (tick)
		begin
			case (st_q)
				DDU_IDLE:
				begin
					fr_d = 1'b1;
					sclk_d = 1'b1;
					if (fifo_v)
					begin
						pop_r = 1'b1;
						tx_d = {fifo_d[22:0], 1'b0};
						sdi_d = fifo_d[23];
						fr_d = 1'b0;
						bit_d = 5'd0;
						st_d = DDU_HIGH;
					end
				end
				DDU_HIGH:
				begin
					sclk_d = 1'b0;
					rx_d = {rx_q[22:0], so_s[1]};
					st_d = DDU_LOW;
				end
				DDU_LOW:
				begin
					sclk_d = 1'b1;
					bit_d = bit_q + 5'd1;
					if (bit_q == 5'(DDU_FRAME_BITS - 1))
					begin
						rb_d = rx_q;
						st_d = DDU_GAP;
					end
					else
					begin
						sdi_d = tx_q[23];
						tx_d = {tx_q[22:0], 1'b0};
						st_d = DDU_HIGH;
					end
				end
				DDU_GAP:
				begin
					fr_d = 1'b1;
					st_d = DDU_IDLE;
				end
				default: st_d = DDU_IDLE;
			endcase
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
			awa_q <= '0; wd_q <= '0; rd_q <= '0; br_q <= '0; rr_q <= '0;
			ctrl_q <= 4'h3;
			st_q <= DDU_IDLE; tx_q <= '0; rx_q <= '0; rb_q <= '0; bit_q <= '0;
			div_q <= '0; sclk_q <= 1'b1; fr_q <= 1'b1; sdi_q <= 1'b0;
			awrdy_q <= 1'b1;
			wrdy_q <= 1'b1;
			arrdy_q <= 1'b1;
		end
		else
		begin
			aw_q <= aw_d; w_q <= w_d; bv_q <= bv_d; rv_q <= rv_d;
			awa_q <= awa_d; wd_q <= wd_d; rd_q <= rd_d; br_q <= br_d; rr_q <= rr_d;
			ctrl_q <= ctrl_d;
			st_q <= st_d; tx_q <= tx_d; rx_q <= rx_d; rb_q <= rb_d; bit_q <= bit_d;
			div_q <= div_d; sclk_q <= sclk_d; fr_q <= fr_d; sdi_q <= sdi_d;
			awrdy_q <= awrdy_d;
			wrdy_q <= wrdy_d;
			arrdy_q <= arrdy_d;
		end
	end
	assign s_axi_awready = awrdy_q;
	assign s_axi_wready  = wrdy_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = br_q;
	assign s_axi_arready = arrdy_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rdata   = rd_q;
	assign s_axi_rresp   = rr_q;
	assign link.frame_n  = fr_q;
	assign link.sclk     = sclk_q;
	assign link.serial_data_in     = sdi_q;
	assign link.load_strobe_n      = ctrl_q[0];
	assign link.reset_n            = ctrl_q[1];
	assign link.reset_level_select = ctrl_q[2];
	assign link.gain_select        = ctrl_q[3];
endmodule

// File: bench/ddu_link_props.sv
// Link checks between the host end and the converter end
module ddu_link_props
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic frame_n,
	input wire logic sclk,
	input wire logic serial_data_in,
	input wire logic serial_data_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] falls_q;
	logic [4:0] falls_d;
	logic       sclk_q;
	logic       frame_q;

	// Cleared at frame start, so a fall that lands with the frame end still counts
	always_comb
	begin
		falls_d = falls_q;
		if (frame_q && !frame_n)
			falls_d = 5'h00;
		else if (sclk_q && !sclk)
			falls_d = falls_q + 5'h01;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			falls_q <= 5'h00;
			sclk_q  <= 1'b1;
			frame_q <= 1'b1;
		end
		else
		begin
			falls_q <= falls_d;
			sclk_q  <= sclk;
			frame_q <= frame_n;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_low_half;
		!sclk [*8] ##1 sclk;
	endsequence
	sequence s_first_fall;
		sclk ##[1:17] !sclk;
	endsequence
	sequence s_frame_gap;
		frame_n [*8];
	endsequence

	property p_bit_held;
		$fell(sclk) |-> $stable(serial_data_in);
	endproperty
	property p_fall_shape;
		$fell(sclk) |-> s_low_half;
	endproperty
	property p_in_on_rise;
		!frame_n && $changed(serial_data_in) |-> sclk;
	endproperty
	property p_frame_start;
		$fell(frame_n) |-> s_first_fall;
	endproperty
	property p_frame_count;
		$rose(frame_n) |-> ##1 falls_q == 5'h18;
	endproperty
	property p_no_overrun;
		!frame_n |-> falls_q <= 5'h18;
	endproperty
	property p_frame_gap;
		$rose(frame_n) |-> s_frame_gap;
	endproperty
	property p_out_on_rise;
		!frame_n && $changed(serial_data_out) |-> sclk;
	endproperty

	a_bit_held: assert property (p_bit_held) else $error("data moved at a clock fall");
	a_fall_shape: assert property (p_fall_shape) else $error("clock low phase wrong");
	a_in_on_rise: assert property (p_in_on_rise) else $error("data moved in low phase");
	a_frame_start: assert property (p_frame_start) else $error("no fall after frame start");
	a_frame_count: assert property (p_frame_count) else $error("frame fall count wrong");
	a_no_overrun: assert property (p_no_overrun) else $error("frame too long");
	a_frame_gap: assert property (p_frame_gap) else $error("frame gap too short");
	a_out_on_rise: assert property (p_out_on_rise) else $error("output moved in low phase");
endmodule

// File: bench/dual_dac_serial_update_control_tb_top.sv
// Bench joining host and converter ends over the serial link
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module dual_dac_serial_update_control_tb_top
	import ddu_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, span;
	logic [5:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rnd, seen;
	logic [1:0]  bresp, rresp, rdy;
	logic [15:0] code_a, code_b, c1, c2;
	logic [23:0] w;
	logic [65:0] q_r[$];
	logic [65:0] e;
	logic [1:0]  q_b[$];
	logic [1:0]  eb;
	int          errors, cmp_count;
	ddu_link_if link ();

	ddu_host ddu_host_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
	ddu_device ddu_device_inst (.aclk(aclk), .aresetn(aresetn), .link(link),
		.out_code_a_q(code_a), .out_code_b_q(code_b), .span_double_q(span), .ready_q(rdy));
	ddu_link_props ddu_link_props_inst (.aclk(aclk), .aresetn(aresetn),
		.frame_n(link.frame_n), .sclk(link.sclk), .serial_data_in(link.serial_data_in),
		.serial_data_out(link.serial_data_out));

	always #5 aclk = ~aclk;

	// Response monitor: every answer is judged against the oldest note
	always @(posedge aclk)
	begin
		if (bvalid && bready)
		begin
			eb = q_b.pop_front();
			`CHK("bresp", eb, bresp)
		end
		if (rvalid && rready)
		begin
			e = q_r.pop_front();
			`CHK("rresp", e[33:32], rresp)
			`CHK("rdata", e[31:0] & e[65:34], rdata & e[65:34])
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
		q_b.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] m, d, input logic [1:0] r);
		q_r.push_back({m, r, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		seen = rdata;
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic ctrl(input logic [3:0] v);
		wr(DDU_OFS_CTRL, {28'h0000000, v}, DDU_RESP_OKAY);
		repeat (8) @(posedge aclk);
	endtask

	task automatic send(input logic [23:0] v);
		wr(DDU_OFS_WORD, {8'h00, v}, DDU_RESP_OKAY);
	endtask

	// Polls until the FIFO is empty and the serial engine is quiet
	task automatic idle();
		int n;
		n = 0;
		do
		begin
			rd(DDU_OFS_STATUS, 32'h00000000, 32'h00000000, DDU_RESP_OKAY);
			n++;
		end while (seen[1:0] !== 2'b00 && n < 2000);
		if (n >= 2000) errors++;
		repeat (16) @(posedge aclk);
	endtask

	task automatic outs(input logic [15:0] a, b);
		`CHK("code a", a, code_a)
		`CHK("code b", b, code_b)
	endtask

	initial
	begin
		#1_000_000;
		errors++;
		conclude();
	end

	initial
	begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		rnd = 32'h2E8433D5;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		outs(DDU_ZERO_SCALE, DDU_ZERO_SCALE);
		`CHK("span", 1'b0, span)
		rd(DDU_OFS_CTRL, 32'h0000000F, 32'h00000003, DDU_RESP_OKAY);
		ctrl(4'hB);
		rnd = lfsr(rnd);
		c1 = rnd[15:0];
		c2 = rnd[31:16];
		send({DDU_CMD_WRITE, DDU_CHAN_A, c1});
		send({DDU_CMD_WRITE, DDU_CHAN_B, c2});
		idle();
		outs(DDU_ZERO_SCALE, DDU_ZERO_SCALE);
		`CHK("span", 1'b1, span)
		ctrl(4'hA);
		ctrl(4'hB);
		outs(c1, c2);
		send({DDU_CMD_WRITE, DDU_CHAN_A | DDU_CHAN_B, DDU_FULL_SCALE});
		idle();
		ctrl(4'hA);
		ctrl(4'hB);
		outs(DDU_FULL_SCALE, DDU_FULL_SCALE);
		ctrl(4'hF);
		ctrl(4'hD);
		outs(DDU_MID_SCALE, DDU_MID_SCALE);
		send({DDU_CMD_WRITE, DDU_CHAN_A, c2});
		idle();
		ctrl(4'hC);
		outs(DDU_MID_SCALE, DDU_MID_SCALE);
		ctrl(4'hD);
		ctrl(4'hE);
		rnd = lfsr(rnd);
		w = {DDU_CMD_WRITE, DDU_CHAN_A, rnd[15:0]};
		send(w);
		send({DDU_CMD_WR_UPD, DDU_CHAN_B, rnd[31:16]});
		idle();
		outs(rnd[15:0], rnd[31:16]);
		rd(DDU_OFS_RDBK, 32'h00FFFFFF, {8'h00, w}, DDU_RESP_OKAY);
		send({4'h8, 4'h0, 16'h0000});
		send(24'h000000);
		idle();
		rd(DDU_OFS_RDBK, 32'h00FFFFFF, {16'h0000, rnd[15:0]}, DDU_RESP_OKAY);
		send({DDU_CMD_POWER, 4'h0, 16'h0001});
		idle();
		`CHK("ready a", 1'b0, rdy[0])
		send({DDU_CMD_POWER, 4'h0, 16'h0000});
		idle();
		`CHK("ready a", 1'b0, rdy[0])
		repeat (DDU_PWRUP_CYC) @(posedge aclk);
		`CHK("ready", 2'b11, rdy)
		ctrl(4'hF);
		for (int i = 0; i < 10; i++)
		begin
			if (i == 9) rd(DDU_OFS_STATUS, 32'h00000006, 32'h00000006, DDU_RESP_OKAY);
			send({DDU_CMD_WRITE, DDU_CHAN_B, 16'(i)});
		end
		idle();
		ctrl(4'hE);
		ctrl(4'hF);
		outs(rnd[15:0], 16'h0009);
		rd(6'h10, 32'hFFFFFFFF, 32'h00000000, DDU_RESP_SLVERR);
		wr(6'h10, 32'h00000000, DDU_RESP_SLVERR);
		rd(DDU_OFS_CTRL, 32'h0000000F, 32'h0000000F, DDU_RESP_OKAY);
		conclude();
	end
endmodule
